// file: logic/serial_port_pkg.sv
// Purpose: shared constants of the serial port with its rate sources
// Assumes: one core clock, special-function register bus of the core
// Notes: register offsets are the byte addresses on the core's bus
package serial_port_pkg;

    // =========================================================
    // register addresses
    localparam logic [7:0] ADDR_CTRL = 8'h98;
    localparam logic [7:0] ADDR_DATA = 8'h99;
    localparam logic [7:0] ADDR_FRAC = 8'h9D;
    localparam logic [7:0] ADDR_BAUD_CTRL = 8'h9E;
    localparam logic [7:0] ADDR_POWER = 8'h87;
    localparam logic [7:0] ADDR_TIMER_B_CTRL = 8'hC8;

    // =========================================================
    // field positions
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_ADDR_FILT = 5;
    localparam int CTRL_RX_EN = 4;
    localparam int CTRL_TX_NINTH = 3;
    localparam int CTRL_RX_NINTH = 2;
    localparam int CTRL_TX_DONE = 1;
    localparam int CTRL_RX_DONE = 0;
    localparam int POWER_RATE_DOUBLE = 7;
    localparam int TIMER_B_RX_SEL = 5;
    localparam int TIMER_B_TX_SEL = 4;
    localparam int BAUD_EN_BIT = 7;
    localparam int BAUD_DIV_MSB = 2;
    localparam int FRAC_MSB = 5;

    // =========================================================
    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    // =========================================================
    // timing counts, in core cycles or oversample ticks
    localparam logic [3:0] SHIFT_BIT_LAST = 4'hB;
    localparam logic [3:0] SHIFT_CLK_HIGH = 4'h6;
    localparam logic [3:0] SHIFT_IDX_LAST = 4'h7;
    localparam logic [3:0] OSR_LAST = 4'hF;
    localparam logic [3:0] OSR_MID = 4'h7;
    localparam logic [3:0] IDX_NINTH = 4'h9;
    localparam logic [3:0] IDX_STOP9 = 4'hA;
    localparam logic [7:0] FRAC_BASE = 8'h40;
    localparam logic [6:0] PRESCALE_FULL = 7'h7F;

endpackage

// file: logic/serial_rate_select.sv
// Purpose: picks the oversample tick (16 per bit) for one direction
// Assumes: timer overflows are one-cycle pulses on the core clock
// Notes: one instance for transmit, one for receive
`timescale 1ns/1ps
module serial_rate_select (
    input wire logic clk,
    input wire logic reset,
    input wire logic fixed_rate,
    input wire logic rate_double_bit,
    input wire logic use_timer_b,
    input wire logic baud_timer_enable,
    input wire logic timer_a_ovf,
    input wire logic timer_b_ovf,
    input wire logic baud_tick,
    output logic rate_tick
);

    typedef struct packed {
        logic half;
        logic tick;
    } sel_s;

    sel_s s_r;
    sel_s s_nxt;
    logic ev;
    logic halve;

    always_comb begin
        ev = 1'b0;
        halve = 1'b0;
        s_nxt = s_r;
        if (fixed_rate) begin
            // core/32 bit rate, core/16 when doubled
            ev = 1'b1;
            halve = ~rate_double_bit;
        end else if (baud_timer_enable) begin
            // doubling and timer b selects are ignored here
            ev = baud_tick;
        end else if (use_timer_b) begin
            // sixteen timer b overflows per bit
            ev = timer_b_ovf;
        end else begin
            ev = timer_a_ovf;
            halve = ~rate_double_bit;
        end
        s_nxt.tick = ev & (~halve | s_r.half);
        if (ev) begin
            s_nxt.half = ~s_r.half;
        end
        if (reset) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign rate_tick = s_r.tick;

endmodule

// file: logic/serial_port.sv
// Purpose: full-duplex serial port with its own fractional rate timer
// Assumes: timers a and b live outside and give one-cycle overflow pulses
// Notes: register reads return data one cycle after the address
`timescale 1ns/1ps
module serial_port (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WE,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    input wire logic TIMER_A_OVF,
    input wire logic TIMER_B_OVF,
    input wire logic RXD_IN,
    output logic RXD_OUT,
    output logic RXD_OE_N,
    output logic TXD
);

    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_RUN} tx_state_e;
    typedef enum logic {RX_IDLE, RX_RUN} rx_state_e;

    typedef struct packed {
        logic mode_select_hi;
        logic mode_select_lo;
        logic addr_filter_enable;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
        logic rate_double_bit;
        logic timer_b_tx_rate_sel;
        logic timer_b_rx_rate_sel;
        logic baud_timer_enable;
        logic [2:0] baud_div;
        logic [5:0] fraction_trim_value;
        logic [7:0] rx_buf;
        logic [7:0] rdata;
        tx_state_e tx_st;
        logic [8:0] tx_data;
        logic [3:0] tx_idx;
        logic [3:0] tx_sub;
        logic txd;
        logic rxd_out;
        logic rxd_oe_n;
        rx_state_e rx_st;
        logic [3:0] rx_idx;
        logic [3:0] rx_sub;
        logic [7:0] rx_sh;
        logic rx_ninth;
        logic sync1;
        logic sync2;
        logic sync3;
        logic rxd_f;
        logic rxd_prev;
        logic [6:0] pre;
        logic [6:0] acc;
        logic baud_tick;
    } port_s;

    port_s s_r;
    port_s s_nxt;
    logic tx_tick;
    logic rx_tick;
    logic shift_mode;
    logic nine_bit;
    logic fixed_mode;

    assign shift_mode = ~s_r.mode_select_hi & ~s_r.mode_select_lo;
    assign nine_bit = s_r.mode_select_hi;
    assign fixed_mode = s_r.mode_select_hi & ~s_r.mode_select_lo;

    // bit on the line for frame position i: start, data, ninth, stop
    function automatic logic frame_bit(input logic [8:0] d,
                                       input logic [3:0] i);
        logic b;
        b = 1'b1;
        if (i == 4'h0) begin
            b = 1'b0;
        end else if (i <= 4'h8) begin
            b = d[3'(i - 4'h1)];
        end else if (i == serial_port_pkg::IDX_NINTH) begin
            b = d[8];
        end
        return b;
    endfunction

    // =========================================================
    // rate selection per direction
    serial_rate_select u_tx_rate (
        .clk(CORE_CLK),
        .reset(RESET),
        .fixed_rate(fixed_mode),
        .rate_double_bit(s_r.rate_double_bit),
        .use_timer_b(s_r.timer_b_tx_rate_sel),
        .baud_timer_enable(s_r.baud_timer_enable),
        .timer_a_ovf(TIMER_A_OVF),
        .timer_b_ovf(TIMER_B_OVF),
        .baud_tick(s_r.baud_tick),
        .rate_tick(tx_tick)
    );

    serial_rate_select u_rx_rate (
        .clk(CORE_CLK),
        .reset(RESET),
        .fixed_rate(fixed_mode),
        .rate_double_bit(s_r.rate_double_bit),
        .use_timer_b(s_r.timer_b_rx_rate_sel),
        .baud_timer_enable(s_r.baud_timer_enable),
        .timer_a_ovf(TIMER_A_OVF),
        .timer_b_ovf(TIMER_B_OVF),
        .baud_tick(s_r.baud_tick),
        .rate_tick(rx_tick)
    );

    always_comb begin
        logic [3:0] last_idx;
        logic [3:0] nidx;
        logic [7:0] sum;
        logic [7:0] lim;
        logic [7:0] rsh;
        logic b;
        last_idx = nine_bit ? serial_port_pkg::IDX_STOP9
                            : serial_port_pkg::IDX_NINTH;
        nidx = 4'h0;
        sum = 8'h00;
        lim = 8'h00;
        rsh = 8'h00;
        b = 1'b0;
        s_nxt = s_r;
        s_nxt.baud_tick = 1'b0;

        // =====================================================
        // receive pin: three stages, change taken when 2 and 3 agree
        s_nxt.sync1 = RXD_IN;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;
        if (s_r.sync2 == s_r.sync3) begin
            s_nxt.rxd_f = s_r.sync3;
        end
        s_nxt.rxd_prev = s_r.rxd_f;

        // =====================================================
        // register reads
        if (SFR_ADDR == serial_port_pkg::ADDR_CTRL) begin
            s_nxt.rdata = {s_r.mode_select_hi, s_r.mode_select_lo,
                           s_r.addr_filter_enable, s_r.rx_enable,
                           s_r.tx_ninth_bit, s_r.rx_ninth_bit,
                           s_r.tx_done_flag, s_r.rx_done_flag};
        end else if (SFR_ADDR == serial_port_pkg::ADDR_DATA) begin
            s_nxt.rdata = s_r.rx_buf;
        end else if (SFR_ADDR == serial_port_pkg::ADDR_POWER) begin
            s_nxt.rdata = {s_r.rate_double_bit, 7'h00};
        end else if (SFR_ADDR == serial_port_pkg::ADDR_TIMER_B_CTRL) begin
            s_nxt.rdata = {2'h0, s_r.timer_b_rx_rate_sel,
                           s_r.timer_b_tx_rate_sel, 4'h0};
        end else if (SFR_ADDR == serial_port_pkg::ADDR_BAUD_CTRL) begin
            s_nxt.rdata = {s_r.baud_timer_enable, 4'h0, s_r.baud_div};
        end else if (SFR_ADDR == serial_port_pkg::ADDR_FRAC) begin
            s_nxt.rdata = {2'h0, s_r.fraction_trim_value};
        end else begin
            s_nxt.rdata = 8'h00;
        end

        // =====================================================
        // register writes; hardware flag sets below win over these
        if (SFR_WE) begin
            if (SFR_ADDR == serial_port_pkg::ADDR_CTRL) begin
                s_nxt.mode_select_hi =
                    SFR_WDATA[serial_port_pkg::CTRL_MODE_HI];
                s_nxt.mode_select_lo =
                    SFR_WDATA[serial_port_pkg::CTRL_MODE_LO];
                s_nxt.addr_filter_enable =
                    SFR_WDATA[serial_port_pkg::CTRL_ADDR_FILT];
                s_nxt.rx_enable = SFR_WDATA[serial_port_pkg::CTRL_RX_EN];
                s_nxt.tx_ninth_bit =
                    SFR_WDATA[serial_port_pkg::CTRL_TX_NINTH];
                s_nxt.rx_ninth_bit =
                    SFR_WDATA[serial_port_pkg::CTRL_RX_NINTH];
                s_nxt.tx_done_flag =
                    SFR_WDATA[serial_port_pkg::CTRL_TX_DONE];
                s_nxt.rx_done_flag =
                    SFR_WDATA[serial_port_pkg::CTRL_RX_DONE];
            end else if (SFR_ADDR == serial_port_pkg::ADDR_POWER) begin
                s_nxt.rate_double_bit =
                    SFR_WDATA[serial_port_pkg::POWER_RATE_DOUBLE];
            end else if (SFR_ADDR == serial_port_pkg::ADDR_TIMER_B_CTRL)
            begin
                s_nxt.timer_b_rx_rate_sel =
                    SFR_WDATA[serial_port_pkg::TIMER_B_RX_SEL];
                s_nxt.timer_b_tx_rate_sel =
                    SFR_WDATA[serial_port_pkg::TIMER_B_TX_SEL];
            end else if (SFR_ADDR == serial_port_pkg::ADDR_BAUD_CTRL) begin
                s_nxt.baud_timer_enable =
                    SFR_WDATA[serial_port_pkg::BAUD_EN_BIT];
                s_nxt.baud_div = SFR_WDATA[serial_port_pkg::BAUD_DIV_MSB:0];
            end else if (SFR_ADDR == serial_port_pkg::ADDR_FRAC) begin
                s_nxt.fraction_trim_value =
                    SFR_WDATA[serial_port_pkg::FRAC_MSB:0];
            end
        end

        // =====================================================
        // dedicated baud timer: binary prescale then a fractional
        // accumulator; averages 16 ticks per bit, jitter under a tick
        if (s_r.pre == (serial_port_pkg::PRESCALE_FULL >>
                        (3'h7 - s_r.baud_div))) begin
            s_nxt.pre = 7'h00;
            sum = {1'b0, s_r.acc} + serial_port_pkg::FRAC_BASE;
            lim = {2'h0, s_r.fraction_trim_value} +
                  serial_port_pkg::FRAC_BASE;
            if (sum >= lim) begin
                s_nxt.acc = 7'(sum - lim);
                s_nxt.baud_tick = s_r.baud_timer_enable;
            end else begin
                s_nxt.acc = sum[6:0];
            end
        end else begin
            s_nxt.pre = s_r.pre + 7'h01;
        end

        // =====================================================
        // transmitter
        case (s_r.tx_st)
            TX_IDLE: begin
            end
            TX_WAIT: begin
                if (tx_tick) begin
                    // the frame aligns to the next rate clock
                    s_nxt.tx_st = TX_RUN;
                    s_nxt.tx_idx = 4'h0;
                    s_nxt.tx_sub = 4'h0;
                    s_nxt.txd = 1'b0;
                end
            end
            TX_RUN: begin
                if (shift_mode) begin
                    if (s_r.tx_sub == serial_port_pkg::SHIFT_BIT_LAST) begin
                        s_nxt.tx_sub = 4'h0;
                        if (s_r.tx_idx == serial_port_pkg::SHIFT_IDX_LAST)
                        begin
                            s_nxt.tx_st = TX_IDLE;
                            s_nxt.txd = 1'b1;
                            s_nxt.rxd_oe_n = 1'b1;
                            s_nxt.tx_done_flag = 1'b1;
                        end else begin
                            nidx = s_r.tx_idx + 4'h1;
                            s_nxt.tx_idx = nidx;
                            s_nxt.rxd_out = s_r.tx_data[3'(nidx)];
                            s_nxt.txd = 1'b0;
                        end
                    end else begin
                        s_nxt.tx_sub = s_r.tx_sub + 4'h1;
                        s_nxt.txd = (s_r.tx_sub + 4'h1) >=
                                    serial_port_pkg::SHIFT_CLK_HIGH;
                    end
                end else if (tx_tick) begin
                    if (s_r.tx_sub == serial_port_pkg::OSR_LAST) begin
                        s_nxt.tx_sub = 4'h0;
                        if (s_r.tx_idx == last_idx) begin
                            s_nxt.tx_st = TX_IDLE;
                            s_nxt.txd = 1'b1;
                        end else begin
                            nidx = s_r.tx_idx + 4'h1;
                            s_nxt.tx_idx = nidx;
                            s_nxt.txd = frame_bit(s_r.tx_data, nidx);
                            if (nidx == last_idx) begin
                                s_nxt.tx_done_flag = 1'b1;
                            end
                        end
                    end else begin
                        s_nxt.tx_sub = s_r.tx_sub + 4'h1;
                    end
                end
            end
            default: begin
                s_nxt.tx_st = TX_IDLE;
            end
        endcase

        // =====================================================
        // receiver
        case (s_r.rx_st)
            RX_IDLE: begin
                if (shift_mode) begin
                    if (s_r.rx_enable && !s_r.rx_done_flag &&
                        s_r.tx_st == TX_IDLE) begin
                        s_nxt.rx_st = RX_RUN;
                        s_nxt.rx_idx = 4'h0;
                        s_nxt.rx_sub = 4'h0;
                        s_nxt.txd = 1'b0;
                    end
                end else if (s_r.rx_enable && s_r.rxd_prev &&
                             !s_r.rxd_f) begin
                    s_nxt.rx_st = RX_RUN;
                    s_nxt.rx_idx = 4'h0;
                    s_nxt.rx_sub = 4'h0;
                end
            end
            RX_RUN: begin
                if (shift_mode) begin
                    if (s_r.rx_sub == serial_port_pkg::SHIFT_BIT_LAST) begin
                        s_nxt.rx_sub = 4'h0;
                        rsh = {s_r.rxd_f, s_r.rx_sh[7:1]};
                        s_nxt.rx_sh = rsh;
                        if (s_r.rx_idx == serial_port_pkg::SHIFT_IDX_LAST)
                        begin
                            s_nxt.rx_st = RX_IDLE;
                            s_nxt.txd = 1'b1;
                            s_nxt.rx_buf = rsh;
                            s_nxt.rx_done_flag = 1'b1;
                        end else begin
                            s_nxt.rx_idx = s_r.rx_idx + 4'h1;
                            s_nxt.txd = 1'b0;
                        end
                    end else begin
                        s_nxt.rx_sub = s_r.rx_sub + 4'h1;
                        s_nxt.txd = (s_r.rx_sub + 4'h1) >=
                                    serial_port_pkg::SHIFT_CLK_HIGH;
                    end
                end else if (rx_tick) begin
                    if (s_r.rx_sub == serial_port_pkg::OSR_LAST) begin
                        s_nxt.rx_sub = 4'h0;
                        s_nxt.rx_idx = s_r.rx_idx + 4'h1;
                    end else begin
                        s_nxt.rx_sub = s_r.rx_sub + 4'h1;
                    end
                    if (s_r.rx_sub == serial_port_pkg::OSR_MID) begin
                        b = s_r.rxd_f;
                        if (s_r.rx_idx == 4'h0) begin
                            if (b) begin
                                s_nxt.rx_st = RX_IDLE;
                            end
                        end else if (s_r.rx_idx <= 4'h8) begin
                            s_nxt.rx_sh = {b, s_r.rx_sh[7:1]};
                        end else if (s_r.rx_idx == serial_port_pkg::IDX_NINTH
                                     && nine_bit) begin
                            s_nxt.rx_ninth = b;
                        end else begin
                            // mid-stop: keep or drop the whole frame
                            s_nxt.rx_st = RX_IDLE;
                            if (!s_r.rx_done_flag && b &&
                                !(nine_bit && s_r.addr_filter_enable &&
                                  !s_r.rx_ninth)) begin
                                s_nxt.rx_buf = s_r.rx_sh;
                                s_nxt.rx_ninth_bit = nine_bit ?
                                    s_r.rx_ninth : b;
                                s_nxt.rx_done_flag = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                s_nxt.rx_st = RX_IDLE;
            end
        endcase

        // =====================================================
        // data write starts a new transmission, cutting any old one
        if (SFR_WE && SFR_ADDR == serial_port_pkg::ADDR_DATA) begin
            s_nxt.tx_sub = 4'h0;
            s_nxt.tx_idx = 4'h0;
            if (shift_mode) begin
                s_nxt.tx_data = {1'b1, SFR_WDATA};
                s_nxt.tx_st = TX_RUN;
                s_nxt.rxd_out = SFR_WDATA[0];
                s_nxt.rxd_oe_n = 1'b0;
                s_nxt.txd = 1'b0;
            end else begin
                s_nxt.tx_data = {nine_bit ? s_r.tx_ninth_bit : 1'b1,
                                 SFR_WDATA};
                s_nxt.tx_st = TX_WAIT;
            end
        end

        if (RESET) begin
            s_nxt = '0;
            s_nxt.rx_buf = serial_port_pkg::REG_RESET;
            s_nxt.txd = 1'b1;
            s_nxt.rxd_out = 1'b1;
            s_nxt.rxd_oe_n = 1'b1;
            s_nxt.sync1 = 1'b1;
            s_nxt.sync2 = 1'b1;
            s_nxt.sync3 = 1'b1;
            s_nxt.rxd_f = 1'b1;
            s_nxt.rxd_prev = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        s_r <= s_nxt;
    end

    assign SFR_RDATA = s_r.rdata;
    assign RXD_OUT = s_r.rxd_out;
    assign RXD_OE_N = s_r.rxd_oe_n;
    assign TXD = s_r.txd;

endmodule

// file: bench/serial_port_assertions.sv
// Purpose: port-level checks of the serial port
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
module serial_port_assertions (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WE,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    input wire logic RXD_OE_N,
    input wire logic TXD
);
    default clocking cb @(posedge CORE_CLK); endclocking
    a_reset_tx_idle: assert property (RESET |=> TXD)
        else $error("txd not idle after reset");
    a_reset_pin_off: assert property (RESET |=> RXD_OE_N)
        else $error("receive pin driven after reset");
    a_reset_rd_zero: assert property (RESET |=> SFR_RDATA == 8'h00)
        else $error("read data not zero after reset");
    a_unmapped_zero: assert property (disable iff (RESET)
        SFR_ADDR == 8'h00 |=> SFR_RDATA == 8'h00)
        else $error("unmapped address read not zero");
    a_frac_res_zero: assert property (disable iff (RESET)
        SFR_ADDR == serial_port_pkg::ADDR_FRAC |=> SFR_RDATA[7:6] == 2'h0)
        else $error("fraction spare bits not zero");
    a_baud_res_zero: assert property (disable iff (RESET)
        SFR_ADDR == serial_port_pkg::ADDR_BAUD_CTRL
        |=> (SFR_RDATA & 8'h78) == 8'h00)
        else $error("baud control spare bits not zero");
    a_timer_res_zero: assert property (disable iff (RESET)
        SFR_ADDR == serial_port_pkg::ADDR_TIMER_B_CTRL
        |=> (SFR_RDATA & 8'hCF) == 8'h00)
        else $error("timer select spare bits not zero");
    a_power_res_zero: assert property (disable iff (RESET)
        SFR_ADDR == serial_port_pkg::ADDR_POWER |=> SFR_RDATA[6:0] == 7'h00)
        else $error("power spare bits not zero");
    // mode, filter, enable and ninth bit are software-only fields
    a_ctrl_readback: assert property (disable iff (RESET)
        SFR_WE && SFR_ADDR == serial_port_pkg::ADDR_CTRL ##1
        !SFR_WE && SFR_ADDR == serial_port_pkg::ADDR_CTRL
        |=> (SFR_RDATA & 8'hF8) == ($past(SFR_WDATA, 2) & 8'hF8))
        else $error("control fields not read back");
endmodule
bind serial_port serial_port_assertions i_serial_port_assertions (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .SFR_ADDR(SFR_ADDR),
    .SFR_WE(SFR_WE), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .RXD_OE_N(RXD_OE_N), .TXD(TXD));

// file: bench/serial_peer.sv
// Purpose: remote serial device driving the receive pin
// Assumes: sixteen core cycles per bit
// Notes: line idles high, as with a pull-up
`timescale 1ns/1ps
module serial_peer (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;
    // frame is {stop, ninth, data, start}, sent lsb first
    task automatic send(input logic [10:0] f);
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            line <= f[i];
            repeat (15) @(posedge clk);
        end
        @(posedge clk);
        line <= 1'b1;
    endtask
endmodule

// file: bench/serial_port_test.sv
// Purpose: self-checking bench of the serial port in all four modes
// Assumes: rate doubling on, so a fixed-mode bit lasts 16 core cycles
// Notes: timer overflows come from a free-running counter
`timescale 1ns/1ps
module serial_port_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic we = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic rxd_out, oe_n, txd, peer_line, rxd;
    logic [1:0] tcnt = 2'h0;
    logic ovf_a, ovf_b;
    logic [7:0] map [7] = '{8'h98, 8'h99, 8'h9D, 8'h9E, 8'h87, 8'hC8, 8'h00};
    int n_errors = 0;
    int samples_checked = 0;
    assign rxd = oe_n ? peer_line : rxd_out;
    always #25 clk = ~clk;
    // stand-in for timers a and b, their interrupts left unused
    always @(posedge clk) tcnt <= tcnt + 2'h1;
    assign ovf_a = tcnt[0];
    assign ovf_b = &tcnt;
    serial_port i_serial_port (.CORE_CLK(clk), .RESET(rst), .SFR_ADDR(addr),
        .SFR_WE(we), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .TIMER_A_OVF(ovf_a), .TIMER_B_OVF(ovf_b), .RXD_IN(rxd),
        .RXD_OUT(rxd_out), .RXD_OE_N(oe_n), .TXD(txd));
    serial_peer i_serial_peer (.clk(clk), .line(peer_line));
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a,
        input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(n, e, rdata);
    endtask
    task automatic t_tx(input logic [7:0] c, input int p,
        input logic [7:0] a, input logic [7:0] v);
        logic [10:0] f;
        int i;
        wr(a, v);
        rd_chk("rate setup", a, v);
        wr(serial_port_pkg::ADDR_CTRL, c);
        wr(serial_port_pkg::ADDR_DATA, 8'hA5);
        i = 0;
        while (txd !== 1'b0 && i < 40) begin
            @(negedge clk);
            i++;
        end
        chk("start wait", 8'h01, {7'h0, i < 20});
        repeat (p / 2) @(negedge clk);
        for (int b = 0; b < 11; b++) begin
            f[b] = txd;
            repeat (p) @(negedge clk);
        end
        chk("tx data", 8'hA5, f[8:1]);
        chk("tx framing", 8'h06, {5'h0, f[10:9], f[0]});
        rd_chk("tx done", serial_port_pkg::ADDR_CTRL, c | 8'h02);
    endtask
    // div 1, fraction 32: one bit is 2 * 96 / 4 = 48 core cycles
    task automatic t_baud;
        wr(serial_port_pkg::ADDR_FRAC, 8'h20);
        t_tx(8'hC8, 48, serial_port_pkg::ADDR_BAUD_CTRL,
             8'h81);
    endtask
    task automatic t_shift;
        logic [7:0] d, lo, hi, en;
        wr(serial_port_pkg::ADDR_CTRL, 8'h00);
        wr(serial_port_pkg::ADDR_DATA, 8'h6B);
        for (int b = 0; b < 8; b++) begin
            @(negedge clk);
            d[b] = rxd_out;
            lo[b] = txd;
            en[b] = oe_n;
            repeat (6) @(negedge clk);
            hi[b] = txd;
            repeat (5) @(negedge clk);
        end
        chk("shift data", 8'h6B, d);
        chk("shift drive", 8'h00, en);
        chk("shift clock low", 8'h00, lo);
        chk("shift clock high", 8'hFF, hi);
        rd_chk("shift done", serial_port_pkg::ADDR_CTRL, 8'h02);
        chk("shift release", 8'h03, {6'h0, oe_n, txd});
        wr(serial_port_pkg::ADDR_CTRL, 8'h10);
        repeat (100) @(posedge clk);
        rd_chk("shift rx flag", serial_port_pkg::ADDR_CTRL, 8'h11);
        rd_chk("shift rx data", serial_port_pkg::ADDR_DATA, 8'hFF);
    endtask
    task automatic t_rx;
        wr(serial_port_pkg::ADDR_CTRL, 8'h90);
        i_serial_peer.send({2'b11, 8'h3C, 1'b0});
        rd_chk("rx control", serial_port_pkg::ADDR_CTRL, 8'h95);
        rd_chk("rx data", serial_port_pkg::ADDR_DATA, 8'h3C);
    endtask
    // a refused frame must leave flags and buffer as they were
    task automatic t_drop(input logic [7:0] c, input logic [10:0] f);
        wr(serial_port_pkg::ADDR_CTRL, c);
        i_serial_peer.send(f);
        rd_chk("drop control", serial_port_pkg::ADDR_CTRL, c);
        rd_chk("kept data", serial_port_pkg::ADDR_DATA, 8'h3C);
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        foreach (map[k]) rd_chk("reset value", map[k], 8'h00);
        t_tx(8'h88, 16, serial_port_pkg::ADDR_POWER, 8'h80);
        t_tx(8'h48, 32, serial_port_pkg::ADDR_POWER, 8'h80);
        t_tx(8'h40, 64, serial_port_pkg::ADDR_TIMER_B_CTRL,
             8'h10);
        t_baud();
        t_rx();
        t_drop(8'h95, {2'b11, 8'h55, 1'b0});
        t_drop(8'h90, {2'b01, 8'h77, 1'b0});
        t_drop(8'hB0, {2'b10, 8'h11, 1'b0});
        t_shift();
        wrap_up();
    end
    initial begin
        #400000;
        n_errors++;
        wrap_up();
    end
endmodule
